// [common/lecu_pkg.sv]
// Purpose: Constants for the line error counter update block.
// Assumes: Byte-wide register port, one received line symbol per clock.
// Notes: Operation
package lecu_pkg;
    localparam logic [7:0]  ADDR_CFG       = 8'h41;
    localparam logic [7:0]  ADDR_LINE_HI   = 8'h42;
    localparam logic [7:0]  ADDR_LINE_LO   = 8'h43;
    localparam logic [7:0]  ADDR_PATH_HI   = 8'h44;
    localparam logic [7:0]  ADDR_PATH_LO   = 8'h45;
    localparam logic [7:0]  ADDR_FSYNC_HI  = 8'h46;
    localparam logic [7:0]  ADDR_FSYNC_LO  = 8'h47;
    localparam logic [7:0]  ADDR_EBIT_HI   = 8'h48;
    localparam logic [7:0]  ADDR_EBIT_LO   = 8'h49;
    localparam int unsigned CFG_XZ         = 0;
    localparam int unsigned CFG_FSYNC_MOS  = 1;
    localparam int unsigned CFG_FS_REPORT  = 2;
    localparam int unsigned CFG_E1_CV      = 3;
    localparam int unsigned CFG_ACC_MODE   = 4;
    localparam int unsigned CFG_INTERVAL   = 5;
    localparam int unsigned CFG_MANUAL     = 6;
    localparam int unsigned CFG_W          = 7;
    localparam logic [6:0]  CFG_RESET      = 7'h00;
    localparam logic [15:0] CNT_RESET      = 16'h0000;
    localparam logic [15:0] CNT_MAX        = 16'hffff;
    localparam int unsigned CNT_LINE       = 0;
    localparam int unsigned CNT_PATH       = 1;
    localparam int unsigned CNT_FSYNC      = 2;
    localparam int unsigned CNT_EBIT       = 3;
    localparam logic [12:0] T1_SHORT_FRAMES = 13'h14d;
    localparam logic [12:0] E1_SHORT_FRAMES = 13'h1f4;
    localparam logic [12:0] ONE_SEC_FRAMES  = 13'h1f40;
    localparam logic [4:0]  ZRUN_PLAIN     = 5'h10;
    localparam logic [4:0]  ZRUN_B8ZS      = 5'h08;
endpackage

// [design/lecu_top.sv]
// Purpose: Line-code violation detection and error counter update control.
// Assumes: clk is the receive line clock; one symbol on rx_pos/rx_neg per rising edge.
// Notes: Path, frame-sync and E-bit events arrive as pulses from the framer.
`timescale 1ns/100ps
module lecu_top #(
    parameter logic [12:0] ONE_SEC_FRAMES = lecu_pkg::ONE_SEC_FRAMES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       is_e1,
    input  wire logic       b8zs_enable,
    input  wire logic       hdb3_enable,
    input  wire logic       rx_pos,
    input  wire logic       rx_neg,
    input  wire logic       frame_pulse,
    input  wire logic       receive_sync_lost,
    input  wire logic       path_ft_error,
    input  wire logic       path_fs_error,
    input  wire logic       fbit_error,
    input  wire logic       multiframe_oos,
    input  wire logic       ebit_error,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    output logic            timer_tick
);
    typedef struct packed {
        logic [1:0]       pin_a;
        logic [1:0]       pin_b;
        logic [15:0]      sym;
        logic [7:0]       bpv;
        logic             last_pol;
        logic             seen_mark;
        logic             last_bpv_pol;
        logic             seen_bpv;
        logic [4:0]       zrun;
        logic [6:0]       cfg;
        logic             man_prev;
        logic [12:0]      frames;
        logic [3:0][15:0] run;
        logic [3:0][15:0] held;
        logic             tick;
        logic [7:0]       rdata;
    } lecu_state_t;

    lecu_state_t q;
    lecu_state_t d;
    logic [1:0]  cur;
    logic        cur_mark;
    logic        new_bpv;
    logic        cw;
    logic        xz_evt;
    logic        e1_bpv;
    logic        e1_cv;
    logic [4:0]  zthr;
    logic [12:0] limit;
    logic        timed_fire;
    logic        man_fire;
    logic        upd;
    logic [3:0]  ev;
    logic [7:0]  mk;
    logic [7:0]  pl;

    always_comb
    begin
        d        = q;
        d.pin_a  = {rx_pos, rx_neg};
        d.pin_b  = q.pin_a;
        cur      = q.pin_b;
        cur_mark = cur[1] ^ cur[0];
        new_bpv  = cur_mark & q.seen_mark & (cur[1] == q.last_pol);
        if (cur_mark)
        begin
            d.last_pol  = cur[1];
            d.seen_mark = 1'b1;
        end
        d.sym = {q.sym[13:0], cur};
        d.bpv = {q.bpv[6:0], new_bpv};
        for (int i = 0; i < 8; i++)
        begin
            mk[i] = d.sym[2*i+1] ^ d.sym[2*i];
            pl[i] = d.sym[2*i+1];
        end
        // A substitution codeword 000VB0VB hides its two violations.
        cw = b8zs_enable & ~is_e1 & ~mk[7] & ~mk[6] & ~mk[5] & ~mk[2]
            & mk[4] & mk[3] & mk[1] & mk[0] & (pl[4] != pl[3])
            & (pl[1] == pl[3]) & (pl[0] != pl[1]) & d.bpv[4] & d.bpv[1];
        if (cw)
        begin
            d.bpv[4] = 1'b0;
            d.bpv[1] = 1'b0;
        end
        zthr   = b8zs_enable ? lecu_pkg::ZRUN_B8ZS : lecu_pkg::ZRUN_PLAIN;
        xz_evt = ~cur_mark & (q.zrun == zthr - 5'h01);
        if (cur_mark)
        begin
            d.zrun = 5'h00;
        end
        else if (q.zrun != zthr)
        begin
            d.zrun = q.zrun + 5'h01;
        end
        // Violations after two zeros are substitution codewords.
        e1_bpv = new_bpv & ~(hdb3_enable & ~(q.sym[1] ^ q.sym[0])
            & ~(q.sym[3] ^ q.sym[2]));
        e1_cv  = new_bpv & q.seen_bpv & (cur[1] == q.last_bpv_pol);
        if (new_bpv)
        begin
            d.last_bpv_pol = cur[1];
            d.seen_bpv     = 1'b1;
        end
        // Line events are never gated by loss of sync.
        if (is_e1)
        begin
            ev[lecu_pkg::CNT_LINE] = q.cfg[lecu_pkg::CFG_E1_CV] ? e1_cv : e1_bpv;
        end
        else
        begin
            ev[lecu_pkg::CNT_LINE] = q.bpv[7] | (q.cfg[lecu_pkg::CFG_XZ] & xz_evt);
        end
        ev[lecu_pkg::CNT_PATH] = ~receive_sync_lost & (path_ft_error
            | (q.cfg[lecu_pkg::CFG_FS_REPORT] & path_fs_error));
        ev[lecu_pkg::CNT_FSYNC] = q.cfg[lecu_pkg::CFG_FSYNC_MOS] ? multiframe_oos
            : (fbit_error & ~receive_sync_lost);
        ev[lecu_pkg::CNT_EBIT] = is_e1 & ebit_error & ~receive_sync_lost;
        if (q.cfg[lecu_pkg::CFG_INTERVAL])
        begin
            limit = is_e1 ? lecu_pkg::E1_SHORT_FRAMES : lecu_pkg::T1_SHORT_FRAMES;
        end
        else
        begin
            limit = ONE_SEC_FRAMES;
        end
        timed_fire = 1'b0;
        if (frame_pulse)
        begin
            if (q.frames >= limit - 13'h0001)
            begin
                d.frames   = 13'h0000;
                timed_fire = ~q.cfg[lecu_pkg::CFG_ACC_MODE];
            end
            else
            begin
                d.frames = q.frames + 13'h0001;
            end
        end
        d.man_prev = q.cfg[lecu_pkg::CFG_MANUAL];
        man_fire   = q.cfg[lecu_pkg::CFG_ACC_MODE] & q.cfg[lecu_pkg::CFG_MANUAL]
            & ~q.man_prev;
        upd        = timed_fire | man_fire;
        d.tick     = timed_fire;
        for (int i = 0; i < 4; i++)
        begin
            if (upd)
            begin
                d.held[i] = q.run[i];
                d.run[i]  = ev[i] ? 16'h0001 : lecu_pkg::CNT_RESET;
            end
            else if (ev[i] && q.run[i] != lecu_pkg::CNT_MAX)
            begin
                d.run[i] = q.run[i] + 16'h0001;
            end
        end
        if (wr_en && addr == lecu_pkg::ADDR_CFG)
        begin
            d.cfg = wdata[lecu_pkg::CFG_W-1:0];
        end
        d.rdata = 8'h00;
        if (rd_en)
        begin
            case (addr)
                lecu_pkg::ADDR_CFG:      d.rdata = {1'b0, q.cfg};
                lecu_pkg::ADDR_LINE_HI:  d.rdata = q.held[lecu_pkg::CNT_LINE][15:8];
                lecu_pkg::ADDR_LINE_LO:  d.rdata = q.held[lecu_pkg::CNT_LINE][7:0];
                lecu_pkg::ADDR_PATH_HI:  d.rdata = q.held[lecu_pkg::CNT_PATH][15:8];
                lecu_pkg::ADDR_PATH_LO:  d.rdata = q.held[lecu_pkg::CNT_PATH][7:0];
                lecu_pkg::ADDR_FSYNC_HI: d.rdata = q.held[lecu_pkg::CNT_FSYNC][15:8];
                lecu_pkg::ADDR_FSYNC_LO: d.rdata = q.held[lecu_pkg::CNT_FSYNC][7:0];
                lecu_pkg::ADDR_EBIT_HI:  d.rdata = q.held[lecu_pkg::CNT_EBIT][15:8];
                lecu_pkg::ADDR_EBIT_LO:  d.rdata = q.held[lecu_pkg::CNT_EBIT][7:0];
                default:                 d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q     <= '0;
            q.cfg <= lecu_pkg::CFG_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata      = q.rdata;
    assign timer_tick = q.tick;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_line_saturate: assert property (($past(q.run[0]) == lecu_pkg::CNT_MAX && !$past(upd))
        |-> q.run[0] == lecu_pkg::CNT_MAX) else $error("line count wrapped");
    chk_count_saturate: assert property ((q.run[1] == lecu_pkg::CNT_MAX && !upd)
        |=> q.run[1] == lecu_pkg::CNT_MAX) else $error("path count wrapped");
    chk_held_stable: assert property (!upd |=> $stable(q.held))
        else $error("held counts changed without update");
    chk_manual_load: assert property (man_fire |=> (q.held[0] == $past(q.run[0]))
        && q.run[0] <= 16'h0001) else $error("manual update did not load");
    chk_manual_quiet: assert property ((q.cfg[lecu_pkg::CFG_ACC_MODE] && !man_fire)
        |=> $stable(q.held)) else $error("update while manual mode idle");
    chk_tick_source: assert property (q.tick |-> $past(frame_pulse)
        && $past(q.frames) == $past(limit) - 13'h0001) else $error("tick off boundary");
    chk_short_bound: assert property ((q.cfg[lecu_pkg::CFG_INTERVAL] && !is_e1)
        |-> q.frames < lecu_pkg::T1_SHORT_FRAMES + 13'h0001) else $error("t1 frame overrun");
    chk_xz_off: assert property ((!is_e1 && !q.cfg[lecu_pkg::CFG_XZ] && !q.bpv[7] && !upd)
        |=> $stable(q.run[0])) else $error("zeros counted while off");
    chk_xz_count: assert property ((!is_e1 && q.cfg[lecu_pkg::CFG_XZ] && xz_evt && !upd
        && q.run[0] != lecu_pkg::CNT_MAX) |=> q.run[0] == $past(q.run[0]) + 16'h0001)
        else $error("excess zeros missed");
    chk_cw_clear: assert property (cw |=> !q.bpv[4] && !q.bpv[1])
        else $error("codeword violations kept");
    chk_cv_mode: assert property ((is_e1 && q.cfg[lecu_pkg::CFG_E1_CV] && !e1_cv && !upd)
        |=> $stable(q.run[0])) else $error("code violation miscounted");
    chk_read_high: assert property ((rd_en && addr == lecu_pkg::ADDR_LINE_HI && !upd)
        |=> rdata == q.held[0][15:8]) else $error("high byte read wrong");
    chk_read_idle: assert property (!rd_en |=> rdata == 8'h00)
        else $error("read data outside read slot");
endmodule

// [test/lecu_line.sv]
// Purpose: Far-end line model giving AMI symbols and frame pulses.
// Assumes: Symbols change on the rising edge; 10 is a positive mark.
// Notes: The idle line alternates marks, so it never violates.
`timescale 1ns/100ps
module lecu_line #(
    parameter int FRAME_LEN = 8
) (
    input  wire logic clk,
    input  wire logic rst,
    output logic      rx_pos,
    output logic      rx_neg,
    output logic      frame_pulse
);
    logic [1:0] sym_q[$];
    logic       pol = 1'b0;
    int         fcnt = 0;
    initial {rx_pos, rx_neg, frame_pulse} = 3'h0;
    always @(posedge clk)
    begin
        if (sym_q.size() != 0)
            {rx_pos, rx_neg} <= sym_q.pop_front();
        else
        begin
            pol = !pol;
            {rx_pos, rx_neg} <= {pol, !pol};
        end
        fcnt = (fcnt == FRAME_LEN - 1) ? 0 : fcnt + 1;
        frame_pulse <= (fcnt == 0) && !rst;
    end
    // Kind 0 queues zeros, 1 alternating marks, 2 marks repeating the last polarity.
    task automatic put(input int kind, input int n);
        @(negedge clk);
        repeat (n)
        begin
            if (kind == 1)
                pol = !pol;
            sym_q.push_back((kind == 0) ? 2'h0 : {pol, !pol});
        end
    endtask
    task automatic drain();
        while (sym_q.size() != 0)
            @(posedge clk);
        repeat (14) @(posedge clk);
    endtask
endmodule

// [test/tb_top.sv]
// Purpose: Self-checking bench for the line error counter update block.
// Assumes: Register reads return data in the cycle after the strobe.
// Notes: A short one-second count and eight-cycle frames keep the run brief.
`timescale 1ns/100ps
module tb_top;
    localparam int FRAME_LEN = 8;
    logic       clk, rst, is_e1, b8zs_enable, hdb3_enable, rx_pos, rx_neg;
    logic       frame_pulse, receive_sync_lost, wr_en, rd_en, timer_tick, path_ft_error;
    logic [7:0] addr, wdata, rdata, b;
    int         fail_count = 0;
    int         tests_run = 0;
    int         n;
    logic [7:0] zc[4] = '{8'h11, 8'h11, 8'h11, 8'h10};
    logic       zb[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    int         zr[4] = '{16, 15, 8, 24};
    logic [7:0] tc[4] = '{8'h00, 8'h20, 8'h20, 8'h00};
    logic       te[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    int         tf[4] = '{16, 333, 500, 16};
    lecu_top #(.ONE_SEC_FRAMES(13'h0010)) lecu_top_i (.clk(clk), .rst(rst), .is_e1(is_e1),
        .b8zs_enable(b8zs_enable), .hdb3_enable(hdb3_enable), .rx_pos(rx_pos), .rx_neg(rx_neg),
        .frame_pulse(frame_pulse), .receive_sync_lost(receive_sync_lost),
        .path_ft_error(path_ft_error),
        .path_fs_error(1'b0), .fbit_error(1'b0), .multiframe_oos(1'b0), .ebit_error(1'b0),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .timer_tick(timer_tick));
    lecu_line #(.FRAME_LEN(FRAME_LEN)) lecu_line_i (.clk(clk), .rst(rst), .rx_pos(rx_pos),
        .rx_neg(rx_neg), .frame_pulse(frame_pulse));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic expect_cnt(input logic [15:0] exp);
        logic [15:0] v;
        rd(lecu_pkg::ADDR_LINE_HI, v[15:8]);
        rd(lecu_pkg::ADDR_LINE_LO, v[7:0]);
        check(v, exp);
    endtask
    task automatic snap(input logic [7:0] cfg);
        wr(lecu_pkg::ADDR_CFG, cfg | 8'h40);
        wr(lecu_pkg::ADDR_CFG, cfg);
        repeat (2) @(posedge clk);
    endtask
    task automatic next_tick(output int c);
        c = 0;
        do
        begin
            @(posedge clk);
            #1 c++;
        end
        while (timer_tick !== 1'b1 && c < 5000);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        fail_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        tally_and_finish();
    end
    initial
    begin
        rst = 1'b1;
        {is_e1, b8zs_enable, hdb3_enable, receive_sync_lost, wr_en, rd_en, path_ft_error} = '0;
        {addr, wdata} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(lecu_pkg::ADDR_CFG, b);
        check(b, 8'h00);
        expect_cnt(16'h0000);
        wr(lecu_pkg::ADDR_CFG, 8'h3f);
        wr(lecu_pkg::ADDR_LINE_HI, 8'hff);
        rd(lecu_pkg::ADDR_CFG, b);
        check(b, 8'h3f);
        rd(8'h50, b);
        check(b, 8'h00);
        expect_cnt(16'h0000);
        $display("registers test done");
        snap(8'h10);
        repeat (3)
        begin
            @(posedge clk);
            path_ft_error <= 1'b1;
            @(posedge clk);
            path_ft_error <= 1'b0;
        end
        snap(8'h10);
        rd(lecu_pkg::ADDR_PATH_HI, b);
        check(b, 8'h00);
        rd(lecu_pkg::ADDR_PATH_LO, b);
        check(b, 8'h03);
        $display("path count test done");
        snap(8'h10);
        lecu_line_i.put(2, 258);
        lecu_line_i.drain();
        snap(8'h10);
        expect_cnt(16'h0102);
        lecu_line_i.put(2, 5);
        lecu_line_i.drain();
        expect_cnt(16'h0102);
        snap(8'h10);
        expect_cnt(16'h0005);
        for (int i = 0; i < 4; i++)
        begin
            b8zs_enable <= zb[i];
            snap(zc[i]);
            lecu_line_i.put(0, zr[i]);
            lecu_line_i.drain();
            snap(zc[i]);
            expect_cnt({15'h0000, i % 2 == 0});
        end
        b8zs_enable <= 1'b1;
        snap(8'h10);
        lecu_line_i.put(0, 3);
        lecu_line_i.put(2, 1);
        lecu_line_i.put(1, 1);
        lecu_line_i.put(0, 1);
        lecu_line_i.put(2, 1);
        lecu_line_i.put(1, 1);
        lecu_line_i.drain();
        snap(8'h10);
        expect_cnt(16'h0000);
        $display("T1 line test done");
        is_e1 <= 1'b1;
        b8zs_enable <= 1'b0;
        receive_sync_lost <= 1'b1;
        snap(8'h10);
        lecu_line_i.put(2, 2);
        lecu_line_i.drain();
        snap(8'h10);
        expect_cnt(16'h0002);
        wr(lecu_pkg::ADDR_CFG, 8'h18);
        lecu_line_i.put(2, 1);
        lecu_line_i.put(1, 61);
        repeat (10) @(posedge clk);
        snap(8'h18);
        lecu_line_i.put(2, 2);
        lecu_line_i.drain();
        snap(8'h18);
        expect_cnt(16'h0001);
        hdb3_enable <= 1'b1;
        snap(8'h10);
        lecu_line_i.put(0, 3);
        lecu_line_i.put(2, 1);
        lecu_line_i.drain();
        snap(8'h10);
        expect_cnt(16'h0000);
        hdb3_enable <= 1'b0;
        snap(8'h10);
        lecu_line_i.put(2, 65540);
        lecu_line_i.drain();
        snap(8'h10);
        expect_cnt(16'hffff);
        $display("E1 line test done");
        for (int i = 0; i < 4; i++)
        begin
            is_e1 <= te[i];
            wr(lecu_pkg::ADDR_CFG, tc[i]);
            next_tick(n);
            next_tick(n);
            lecu_line_i.put(2, 4);
            next_tick(n);
            check(n, tf[i] * FRAME_LEN);
            expect_cnt(16'h0004);
        end
        $display("timed update test done");
        tally_and_finish();
    end
endmodule
